// ===== core/pec_ctrl_regs.v
// paged control register bank of the picture enhancement pipeline
//
// How it works
// R1: dither step code 0 pixel, 1 line, 2 frame; 3 to 7 reserved.
// R2: temporal noise reduction runs only while its enable bit is one.
// R3: six-bit noise detector time constant, 0 fastest, 63 slowest.
// R4: six-bit noise filter time constant, 0 fastest, 63 slowest.
// R5: three-bit horizontal coring strength, 0 off, 7 maximum.
// R6: three-bit vertical coring strength in bits six to four.
// R7: two-bit edge ringing reduction level, 0 off, 3 strongest.
// R8: four-bit whole-picture ringing reduction in bits seven to four.
// R9: manual spatial and upscale strengths apply only in manual mode.
// R10: manual combined gain, 32 to 255, applies only in manual mode.
// R11: automatic combined gain register replaces it in automatic mode.
// R12: software keeps minimum text ratio at least 4096 over active gain.
// R13: software should keep maximum text ratio between 96 and 128.
// R14: noise range shift honoured only in automatic mode.
// R15: block noise limit applies only while tone protection is enabled.
// R16: tone protection enable bit seven reduces upscale in pale orange.
// R17: upscale disable bit is active high.
// R18: bit seven selects manual (0) or automatic (1) upscale control.
// R19: tone reduction depth is inverse coded, 0 greatest, 3 least.
// R20: reads return last written value, unimplemented bits as zero.
`timescale 1ns/10ps
`default_nettype none
`include "pec_consts.vh"
module pec_ctrl_regs (
  input wire clk,
  input wire reset,
  input wire [7:0] host_page,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire [7:0] host_wdata,
  input wire host_rd,
  output reg [7:0] host_rdata,
  output reg host_rvalid,
  output reg dither_step_pixel,
  output reg dither_step_line,
  output reg dither_step_frame,
  output reg dither_step_reserved,
  output reg temporal_nr_run,
  output reg [5:0] noise_detector_time_constant,
  output reg [5:0] noise_filter_time_constant,
  output reg [5:0] temporal_nr_min_level,
  output reg [5:0] temporal_nr_max_level,
  output reg [4:0] temporal_nr_peak_level,
  output reg [3:0] temporal_nr_clip_max,
  output reg [5:0] luma_ctrl_default_volume,
  output reg [5:0] luma_ctrl_peak_volume,
  output reg [7:0] luma_ctrl_gradient_high,
  output reg [7:0] luma_ctrl_gradient_low,
  output reg gradation_smoothing_enable,
  output reg [2:0] horizontal_coring_level,
  output reg horizontal_coring_on,
  output reg [2:0] vertical_coring_level,
  output reg vertical_coring_on,
  output reg [1:0] edge_ringing_nr_level,
  output reg edge_ringing_on,
  output reg [3:0] area_ringing_nr_level,
  output reg area_ringing_on,
  output reg upscale_run,
  output reg upscale_auto,
  output reg [7:0] spatial_nr_strength,
  output reg [7:0] upscale_strength,
  output reg [7:0] combined_gain,
  output reg [7:0] text_effect_ratio_min,
  output reg [7:0] text_effect_ratio_max,
  output reg text_ratio_low,
  output reg [3:0] noise_range_shift,
  output reg [3:0] block_noise_limit,
  output reg tone_protect_on,
  output reg [1:0] tone_reduce_amount
);
  localparam NREG = 27;
  localparam [4:0] NONE = 5'h1F;
  localparam I_DITH = 0;
  localparam I_TNR_EN = 1;
  localparam I_DET_TC = 2;
  localparam I_FLT_TC = 3;
  localparam I_TNR_MIN = 4;
  localparam I_TNR_MAX = 5;
  localparam I_TNR_PEAK = 6;
  localparam I_TNR_CLIP = 7;
  localparam I_DEFVOL = 8;
  localparam I_LPEAK = 9;
  localparam I_GRAD_H = 10;
  localparam I_GRAD_L = 11;
  localparam I_GRAD_EN = 12;
  localparam I_CORING = 13;
  localparam I_RINGING = 14;
  localparam I_SNR_MAN = 15;
  localparam I_UPS_MAN = 16;
  localparam I_GAIN_MAN = 17;
  localparam I_RATIO_MIN = 18;
  localparam I_RATIO_MAX = 19;
  localparam I_NS_SHIFT = 20;
  localparam I_GAIN_AUTO = 21;
  localparam I_BLK_LIM = 22;
  localparam I_TONE_EN = 23;
  localparam I_UPS_DIS = 24;
  localparam I_UPS_AUTO = 25;
  localparam I_TONE_DEPTH = 26;

  // page and offset to register index
  function [4:0] idx_of;
    input [7:0] pg;
    input [7:0] ad;
    begin
      case ({pg, ad})
        {`PEC_PG_DITHER, `PEC_A_DITHER_STEP}: idx_of = 5'd0;
        {`PEC_PG_TNR, `PEC_A_TNR_ENABLE}: idx_of = 5'd1;
        {`PEC_PG_TNR, `PEC_A_DET_TC}: idx_of = 5'd2;
        {`PEC_PG_TNR, `PEC_A_FLT_TC}: idx_of = 5'd3;
        {`PEC_PG_TNR, `PEC_A_TNR_MIN}: idx_of = 5'd4;
        {`PEC_PG_TNR, `PEC_A_TNR_MAX}: idx_of = 5'd5;
        {`PEC_PG_TNR, `PEC_A_TNR_PEAK}: idx_of = 5'd6;
        {`PEC_PG_TNR, `PEC_A_TNR_CLIP}: idx_of = 5'd7;
        {`PEC_PG_TNR, `PEC_A_LUMA_DEFVOL}: idx_of = 5'd8;
        {`PEC_PG_TNR, `PEC_A_LUMA_PEAK}: idx_of = 5'd9;
        {`PEC_PG_TNR, `PEC_A_LUMA_GRAD_H}: idx_of = 5'd10;
        {`PEC_PG_TNR, `PEC_A_LUMA_GRAD_L}: idx_of = 5'd11;
        {`PEC_PG_GRC, `PEC_A_GRAD_EN}: idx_of = 5'd12;
        {`PEC_PG_GRC, `PEC_A_CORING}: idx_of = 5'd13;
        {`PEC_PG_GRC, `PEC_A_RINGING}: idx_of = 5'd14;
        {`PEC_PG_UPS, `PEC_A_SNR_MAN}: idx_of = 5'd15;
        {`PEC_PG_UPS, `PEC_A_UPS_MAN}: idx_of = 5'd16;
        {`PEC_PG_UPS, `PEC_A_GAIN_MAN}: idx_of = 5'd17;
        {`PEC_PG_UPS, `PEC_A_RATIO_MIN}: idx_of = 5'd18;
        {`PEC_PG_UPS, `PEC_A_RATIO_MAX}: idx_of = 5'd19;
        {`PEC_PG_UPS, `PEC_A_NS_SHIFT}: idx_of = 5'd20;
        {`PEC_PG_UPS, `PEC_A_GAIN_AUTO}: idx_of = 5'd21;
        {`PEC_PG_UPS, `PEC_A_BLK_LIMIT}: idx_of = 5'd22;
        {`PEC_PG_UPS, `PEC_A_TONE_EN}: idx_of = 5'd23;
        {`PEC_PG_UPS, `PEC_A_UPS_DIS}: idx_of = 5'd24;
        {`PEC_PG_UPS, `PEC_A_UPS_AUTO}: idx_of = 5'd25;
        {`PEC_PG_UPS, `PEC_A_TONE_DEPTH}: idx_of = 5'd26;
        default: idx_of = NONE;
      endcase
    end
  endfunction

  // implemented bits per register index
  function [7:0] mask_of;
    input integer i;
    begin
      case (i)
        I_DITH: mask_of = `PEC_M_DITHER_STEP;
        I_TNR_EN, I_GRAD_EN: mask_of = `PEC_M_BIT0;
        I_DET_TC, I_FLT_TC, I_TNR_MIN, I_TNR_MAX: mask_of = `PEC_M_SIX;
        I_DEFVOL, I_LPEAK: mask_of = `PEC_M_SIX;
        I_TNR_PEAK: mask_of = `PEC_M_TNR_PEAK;
        I_TNR_CLIP, I_BLK_LIM: mask_of = `PEC_M_HIGH_NIB;
        I_CORING: mask_of = `PEC_M_CORING;
        I_RINGING: mask_of = `PEC_M_RINGING;
        I_NS_SHIFT: mask_of = `PEC_M_LOW_NIB;
        I_TONE_EN, I_UPS_DIS, I_UPS_AUTO: mask_of = `PEC_M_BIT7;
        I_TONE_DEPTH: mask_of = `PEC_M_TONE_DEPTH;
        default: mask_of = `PEC_M_FULL;
      endcase
    end
  endfunction

  // reset value per register index
  function [7:0] rst_of;
    input integer i;
    begin
      case (i)
        I_GAIN_MAN, I_GAIN_AUTO: rst_of = `PEC_R_GAIN;
        I_RATIO_MIN: rst_of = `PEC_R_RATIO_MIN;
        I_RATIO_MAX: rst_of = `PEC_R_RATIO_MAX;
        I_NS_SHIFT: rst_of = `PEC_R_NS_SHIFT;
        default: rst_of = `PEC_R_ZERO;
      endcase
    end
  endfunction

  wire [4:0] acc_idx;
  wire [8*NREG-1:0] bank_q;
  reg [7:0] rd_mux;
  integer k;

  assign acc_idx = idx_of(host_page, host_addr);

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : bank
      pec_reg8 #(
        .MASK(mask_of(g)),
        .RST(rst_of(g))
      ) u_reg (
        .clk(clk),
        .reset(reset),
        .we(host_wr && (acc_idx == g)),
        .wdata(host_wdata),
        .q(bank_q[8*g +: 8])
      );
    end
  endgenerate

  // R20: read back of the addressed register
  always @* begin
    rd_mux = 8'h00;
    for (k = 0; k < NREG; k = k + 1) begin
      if (acc_idx == k) begin
        rd_mux = bank_q[8*k +: 8];
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        host_rdata <= rd_mux;
      end
    end
  end

  // field views of the bank
  wire [7:0] dith_q = bank_q[8*I_DITH +: 8];
  wire [7:0] coring_q = bank_q[8*I_CORING +: 8];
  wire [7:0] ringing_q = bank_q[8*I_RINGING +: 8];
  wire [7:0] clip_q = bank_q[8*I_TNR_CLIP +: 8];
  wire [7:0] blk_q = bank_q[8*I_BLK_LIM +: 8];
  wire [7:0] depth_q = bank_q[8*I_TONE_DEPTH +: 8];
  wire tone_en = bank_q[8*I_TONE_EN + `PEC_F_FLAG];
  wire ups_dis = bank_q[8*I_UPS_DIS + `PEC_F_FLAG];
  wire ups_auto = bank_q[8*I_UPS_AUTO + `PEC_F_FLAG];
  wire [7:0] snr_sel;
  wire [7:0] ups_sel;
  wire [7:0] gain_sel;
  wire [3:0] shift_sel;
  wire [3:0] limit_sel;
  wire ratio_low;

  pec_gain_sel u_gain (
    .auto_on(ups_auto),
    .tone_on(tone_en),
    .snr_manual(bank_q[8*I_SNR_MAN +: 8]),
    .ups_manual(bank_q[8*I_UPS_MAN +: 8]),
    .gain_manual(bank_q[8*I_GAIN_MAN +: 8]),
    .gain_auto(bank_q[8*I_GAIN_AUTO +: 8]),
    .ns_shift(bank_q[8*I_NS_SHIFT +: 4]),
    .blk_limit(blk_q[`PEC_F_HI_NIB]),
    .ratio_min(bank_q[8*I_RATIO_MIN +: 8]),
    .snr_sel(snr_sel),
    .ups_sel(ups_sel),
    .gain_sel(gain_sel),
    .shift_sel(shift_sel),
    .limit_sel(limit_sel),
    .ratio_low(ratio_low)
  );

  always @(posedge clk) begin
    if (reset) begin
      dither_step_pixel <= 1'b0;
      dither_step_line <= 1'b0;
      dither_step_frame <= 1'b0;
      dither_step_reserved <= 1'b0;
      temporal_nr_run <= 1'b0;
      noise_detector_time_constant <= 6'h00;
      noise_filter_time_constant <= 6'h00;
      temporal_nr_min_level <= 6'h00;
      temporal_nr_max_level <= 6'h00;
      temporal_nr_peak_level <= 5'h00;
      temporal_nr_clip_max <= 4'h0;
      luma_ctrl_default_volume <= 6'h00;
      luma_ctrl_peak_volume <= 6'h00;
      luma_ctrl_gradient_high <= 8'h00;
      luma_ctrl_gradient_low <= 8'h00;
      gradation_smoothing_enable <= 1'b0;
      horizontal_coring_level <= 3'h0;
      horizontal_coring_on <= 1'b0;
      vertical_coring_level <= 3'h0;
      vertical_coring_on <= 1'b0;
      edge_ringing_nr_level <= 2'h0;
      edge_ringing_on <= 1'b0;
      area_ringing_nr_level <= 4'h0;
      area_ringing_on <= 1'b0;
      upscale_run <= 1'b0;
      upscale_auto <= 1'b0;
      spatial_nr_strength <= 8'h00;
      upscale_strength <= 8'h00;
      combined_gain <= 8'h00;
      text_effect_ratio_min <= 8'h00;
      text_effect_ratio_max <= 8'h00;
      text_ratio_low <= 1'b0;
      noise_range_shift <= 4'h0;
      block_noise_limit <= 4'h0;
      tone_protect_on <= 1'b0;
      tone_reduce_amount <= 2'h0;
    end else begin
      // R1: dither step decode
      dither_step_pixel <= dith_q[2:0] == `PEC_DITH_PIXEL;
      dither_step_line <= dith_q[2:0] == `PEC_DITH_LINE;
      dither_step_frame <= dith_q[2:0] == `PEC_DITH_FRAME;
      dither_step_reserved <= dith_q[2:0] > `PEC_DITH_FRAME;
      // R2: temporal filter enable
      temporal_nr_run <= bank_q[8*I_TNR_EN];
      // R3: detector time constant
      noise_detector_time_constant <= bank_q[8*I_DET_TC +: 6];
      // R4: filter time constant
      noise_filter_time_constant <= bank_q[8*I_FLT_TC +: 6];
      temporal_nr_min_level <= bank_q[8*I_TNR_MIN +: 6];
      temporal_nr_max_level <= bank_q[8*I_TNR_MAX +: 6];
      temporal_nr_peak_level <= bank_q[8*I_TNR_PEAK +: 5];
      temporal_nr_clip_max <= clip_q[`PEC_F_HI_NIB];
      luma_ctrl_default_volume <= bank_q[8*I_DEFVOL +: 6];
      luma_ctrl_peak_volume <= bank_q[8*I_LPEAK +: 6];
      luma_ctrl_gradient_high <= bank_q[8*I_GRAD_H +: 8];
      luma_ctrl_gradient_low <= bank_q[8*I_GRAD_L +: 8];
      gradation_smoothing_enable <= bank_q[8*I_GRAD_EN];
      // R5: horizontal coring, zero is off
      horizontal_coring_level <= coring_q[`PEC_F_HCORE];
      horizontal_coring_on <= |coring_q[`PEC_F_HCORE];
      // R6: vertical coring, zero is off
      vertical_coring_level <= coring_q[`PEC_F_VCORE];
      vertical_coring_on <= |coring_q[`PEC_F_VCORE];
      // R7: edge ringing reduction
      edge_ringing_nr_level <= ringing_q[`PEC_F_EDGE];
      edge_ringing_on <= |ringing_q[`PEC_F_EDGE];
      // R8: whole-picture ringing reduction
      area_ringing_nr_level <= ringing_q[`PEC_F_HI_NIB];
      area_ringing_on <= |ringing_q[`PEC_F_HI_NIB];
      // R17: disable bit active high
      upscale_run <= ~ups_dis;
      // R18: manual or automatic control
      upscale_auto <= ups_auto;
      // R9: gated manual strengths
      spatial_nr_strength <= snr_sel;
      upscale_strength <= ups_sel;
      // R10: active combined gain
      // R11: auto gain when automatic
      combined_gain <= gain_sel;
      text_effect_ratio_min <= bank_q[8*I_RATIO_MIN +: 8];
      text_effect_ratio_max <= bank_q[8*I_RATIO_MAX +: 8];
      // R12: ratio floor status
      text_ratio_low <= ratio_low;
      // R14: gated noise range shift
      noise_range_shift <= shift_sel;
      // R15: gated block noise limit
      block_noise_limit <= limit_sel;
      // R16: pale orange protection
      tone_protect_on <= tone_en;
      // R19: inverse coded reduction depth
      tone_reduce_amount <= ~depth_q[1:0];
    end
  end
endmodule
`default_nettype wire

// ===== core/pec_consts.vh
// register locations, field layouts and reset values of the picture bank
`ifndef PEC_CONSTS_VH
`define PEC_CONSTS_VH

// register pages
`define PEC_PG_DITHER 8'h1F
`define PEC_PG_TNR 8'h1B
`define PEC_PG_GRC 8'h1D
`define PEC_PG_UPS 8'h1C

// offsets within each page
`define PEC_A_DITHER_STEP 8'h09
`define PEC_A_TNR_ENABLE 8'h0C
`define PEC_A_DET_TC 8'h33
`define PEC_A_FLT_TC 8'h34
`define PEC_A_TNR_MIN 8'h22
`define PEC_A_TNR_MAX 8'h23
`define PEC_A_TNR_PEAK 8'h2D
`define PEC_A_TNR_CLIP 8'h2E
`define PEC_A_LUMA_DEFVOL 8'h58
`define PEC_A_LUMA_PEAK 8'h5B
`define PEC_A_LUMA_GRAD_H 8'h5C
`define PEC_A_LUMA_GRAD_L 8'h5D
`define PEC_A_GRAD_EN 8'h2E
`define PEC_A_CORING 8'h2F
`define PEC_A_RINGING 8'h31
`define PEC_A_SNR_MAN 8'h10
`define PEC_A_UPS_MAN 8'h11
`define PEC_A_GAIN_MAN 8'h12
`define PEC_A_RATIO_MIN 8'h1B
`define PEC_A_RATIO_MAX 8'h1C
`define PEC_A_NS_SHIFT 8'h24
`define PEC_A_GAIN_AUTO 8'h3E
`define PEC_A_BLK_LIMIT 8'h6D
`define PEC_A_TONE_EN 8'h80
`define PEC_A_UPS_DIS 8'h86
`define PEC_A_UPS_AUTO 8'h88
`define PEC_A_TONE_DEPTH 8'h8B

// implemented bits of each register
`define PEC_M_FULL 8'hFF
`define PEC_M_DITHER_STEP 8'h07
`define PEC_M_BIT0 8'h01
`define PEC_M_SIX 8'h3F
`define PEC_M_TNR_PEAK 8'h1F
`define PEC_M_HIGH_NIB 8'hF0
`define PEC_M_CORING 8'h77
`define PEC_M_RINGING 8'hF3
`define PEC_M_LOW_NIB 8'h0F
`define PEC_M_BIT7 8'h80
`define PEC_M_TONE_DEPTH 8'h03

// field positions
`define PEC_F_FLAG 7
`define PEC_F_HI_NIB 7:4
`define PEC_F_VCORE 6:4
`define PEC_F_HCORE 2:0
`define PEC_F_EDGE 1:0

// reset values
`define PEC_R_ZERO 8'h00
`define PEC_R_GAIN 8'h20
`define PEC_R_RATIO_MIN 8'h80
`define PEC_R_RATIO_MAX 8'h60
`define PEC_R_NS_SHIFT 8'h04

// dither step codes
`define PEC_DITH_PIXEL 3'h0
`define PEC_DITH_LINE 3'h1
`define PEC_DITH_FRAME 3'h2

// least product of text ratio and active gain
`define PEC_RATIO_FLOOR 16'h1000

`endif

// ===== core/pec_reg8.v
// one host byte register with implemented-bit mask
`timescale 1ns/10ps
`default_nettype none
module pec_reg8 #(
  parameter [7:0] MASK = 8'hFF,
  parameter [7:0] RST = 8'h00
) (
  input wire clk,
  input wire reset,
  input wire we,
  input wire [7:0] wdata,
  output reg [7:0] q
);
  always @(posedge clk) begin
    if (reset) begin
      q <= RST & MASK;
    end else if (we) begin
      // R20: unused bits stay zero
      q <= wdata & MASK;
    end
  end
endmodule
`default_nettype wire

// ===== core/pec_gain_sel.v
// manual or automatic super resolution control selection
`timescale 1ns/10ps
`default_nettype none
module pec_gain_sel (
  input wire auto_on,
  input wire tone_on,
  input wire [7:0] snr_manual,
  input wire [7:0] ups_manual,
  input wire [7:0] gain_manual,
  input wire [7:0] gain_auto,
  input wire [3:0] ns_shift,
  input wire [3:0] blk_limit,
  input wire [7:0] ratio_min,
  output reg [7:0] snr_sel,
  output reg [7:0] ups_sel,
  output reg [7:0] gain_sel,
  output reg [3:0] shift_sel,
  output reg [3:0] limit_sel,
  output reg ratio_low
);
  reg [15:0] prod;
  always @* begin
    // R9: manual strengths only in manual mode
    snr_sel = auto_on ? 8'h00 : snr_manual;
    ups_sel = auto_on ? 8'h00 : ups_manual;
    // R10: manual gain in manual mode
    // R11: automatic gain in automatic mode
    gain_sel = auto_on ? gain_auto : gain_manual;
    // R14: noise range shift in automatic mode only
    shift_sel = auto_on ? ns_shift : 4'h0;
    // R15: block limit gated by tone protection
    limit_sel = tone_on ? blk_limit : 4'h0;
    // R12: flag a text ratio under its floor
    prod = ratio_min * gain_sel;
    ratio_low = prod < `PEC_RATIO_FLOOR;
  end
endmodule
`default_nettype wire

// ===== verification/pec_ctrl_regs_asserts.sv
// concurrent checks on the picture control register bank ports
`timescale 1ns/10ps
`default_nettype none
module pec_ctrl_regs_asserts (
  input wire clk,
  input wire reset,
  input wire [7:0] host_page,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire [7:0] host_wdata,
  input wire host_rd,
  input wire host_rvalid,
  input wire dither_step_pixel,
  input wire dither_step_line,
  input wire dither_step_frame,
  input wire dither_step_reserved,
  input wire [2:0] horizontal_coring_level,
  input wire horizontal_coring_on,
  input wire [3:0] area_ringing_nr_level,
  input wire area_ringing_on,
  input wire upscale_run,
  input wire upscale_auto,
  input wire [7:0] spatial_nr_strength,
  input wire [7:0] upscale_strength,
  input wire [7:0] combined_gain,
  input wire [7:0] text_effect_ratio_min,
  input wire text_ratio_low,
  input wire [3:0] noise_range_shift,
  input wire [3:0] block_noise_limit,
  input wire tone_protect_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  reg [1:0] st_reg;
  wire up;
  wire ups_wr;
  assign up = st_reg[1];
  assign ups_wr = host_wr && host_page == 8'h1C;
  // outputs trustworthy two edges after reset release
  always @(posedge clk) begin
    if (reset) st_reg <= 2'h0;
    else if (st_reg != 2'h3) st_reg <= st_reg + 2'h1;
  end
  read_pulse_a: assert property (host_rd |=> host_rvalid)
    else $error("read not answered by valid");
  no_stray_valid_a: assert property (!host_rd |=> !host_rvalid)
    else $error("valid without read");
  dither_onehot_a: assert property (up |-> $onehot({dither_step_pixel,
    dither_step_line, dither_step_frame, dither_step_reserved}))
    else $error("dither decode not one-hot");
  manual_only_a: assert property (up && upscale_auto |->
    spatial_nr_strength == 8'h00 && upscale_strength == 8'h00)
    else $error("manual strengths leak in auto mode");
  shift_auto_a: assert property (up && !upscale_auto |-> noise_range_shift == 4'h0)
    else $error("noise shift used in manual mode");
  limit_tone_a: assert property (up && !tone_protect_on |-> block_noise_limit == 4'h0)
    else $error("block limit without tone protection");
  coring_on_a: assert property (up |-> horizontal_coring_on ==
    (horizontal_coring_level != 3'h0))
    else $error("coring enable mismatch");
  area_on_a: assert property (up |-> area_ringing_on == (area_ringing_nr_level != 4'h0))
    else $error("area ringing enable mismatch");
  ratio_floor_a: assert property (up && $stable(combined_gain) &&
    $stable(text_effect_ratio_min) |-> text_ratio_low ==
    (({8'h00, text_effect_ratio_min} * {8'h00, combined_gain}) < 16'h1000))
    else $error("text ratio status wrong");
  auto_write_a: assert property (ups_wr && host_addr == 8'h88 |->
    ##2 upscale_auto == $past(host_wdata[7], 2))
    else $error("auto control not following write");
  disable_write_a: assert property (ups_wr && host_addr == 8'h86 |->
    ##2 upscale_run == !$past(host_wdata[7], 2))
    else $error("upscale disable polarity wrong");
  c_read: cover property (host_rd ##1 host_rvalid);
  c_auto: cover property (upscale_auto && combined_gain == 8'hFF);
  c_low: cover property (text_ratio_low);
endmodule
bind pec_ctrl_regs pec_ctrl_regs_asserts chk_u (.clk, .reset, .host_page,
  .host_addr, .host_wr, .host_wdata, .host_rd, .host_rvalid,
  .dither_step_pixel, .dither_step_line, .dither_step_frame,
  .dither_step_reserved, .horizontal_coring_level, .horizontal_coring_on,
  .area_ringing_nr_level, .area_ringing_on, .upscale_run, .upscale_auto,
  .spatial_nr_strength, .upscale_strength, .combined_gain,
  .text_effect_ratio_min, .text_ratio_low, .noise_range_shift,
  .block_noise_limit, .tone_protect_on);
`default_nettype wire

// ===== verification/pec_ctrl_regs_bench.sv
// self-checking bench for the picture control register bank
`timescale 1ns/10ps
`default_nettype none
module pec_ctrl_regs_bench;
  logic clk = 0, reset = 1, host_wr = 0, host_rd = 0;
  logic [7:0] host_page = 0, host_addr = 0, host_wdata = 0;
  wire [7:0] rdata, cgain, smin, sman, uman;
  wire rvalid, pix, lin, frm, rsv, tnr, hon, von, eon, aon, urun, uauto;
  wire low, ton;
  wire [5:0] tmin, tmax, dvol, lpk;
  wire [4:0] tpk;
  wire [3:0] clip;
  wire [7:0] gh, gl, smax;
  wire gen;
  wire [5:0] dtc, ftc;
  wire [2:0] hlev, vlev;
  wire [1:0] elev, tamt;
  wire [3:0] alev, shft, blim;
  int miscompares = 0, comparisons = 0;
  pec_ctrl_regs dut_u (.clk(clk), .reset(reset), .host_page(host_page),
    .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rd(host_rd), .host_rdata(rdata), .host_rvalid(rvalid),
    .dither_step_pixel(pix), .dither_step_line(lin),
    .dither_step_frame(frm), .dither_step_reserved(rsv),
    .temporal_nr_run(tnr), .noise_detector_time_constant(dtc),
    .noise_filter_time_constant(ftc), .temporal_nr_min_level(tmin),
    .temporal_nr_max_level(tmax), .temporal_nr_peak_level(tpk),
    .temporal_nr_clip_max(clip), .luma_ctrl_default_volume(dvol),
    .luma_ctrl_peak_volume(lpk), .luma_ctrl_gradient_high(gh),
    .luma_ctrl_gradient_low(gl), .gradation_smoothing_enable(gen),
    .horizontal_coring_level(hlev), .horizontal_coring_on(hon),
    .vertical_coring_level(vlev), .vertical_coring_on(von),
    .edge_ringing_nr_level(elev), .edge_ringing_on(eon),
    .area_ringing_nr_level(alev), .area_ringing_on(aon),
    .upscale_run(urun), .upscale_auto(uauto),
    .spatial_nr_strength(sman), .upscale_strength(uman),
    .combined_gain(cgain), .text_effect_ratio_min(smin),
    .text_effect_ratio_max(smax), .text_ratio_low(low),
    .noise_range_shift(shft), .block_noise_limit(blim),
    .tone_protect_on(ton), .tone_reduce_amount(tamt));
  initial begin
    forever #2 clk = ~clk;
  end
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t byte got %h want %h", $time, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t bit got %b want %b", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 host_wr = 1;
    host_page = p;
    host_addr = a;
    host_wdata = d;
    @(posedge clk);
    #1 host_wr = 0;
  endtask
  task rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 host_rd = 1;
    host_page = p;
    host_addr = a;
    @(posedge clk);
    #1 host_rd = 0;
    chkb(rvalid, 1'b1);
    chk8(rdata, e);
  endtask
  task settle;
    @(posedge clk);
    #1;
  endtask
  task mask_chk(input logic [7:0] p, input logic [7:0] a, input logic [7:0] m);
    wr(p, a, 8'hFF);
    rd(p, a, m);
  endtask
  task t_reset;
    rd(8'h1C, 8'h12, 8'h20);
    rd(8'h1C, 8'h3E, 8'h20);
    rd(8'h1C, 8'h1B, 8'h80);
    rd(8'h1C, 8'h1C, 8'h60);
    rd(8'h1C, 8'h24, 8'h04);
    rd(8'h1F, 8'h09, 8'h00);
    chkb(pix, 1'b1);
    chkb(urun, 1'b1);
    chk8(cgain, 8'h20);
    chk8({6'h00, tamt}, 8'h03);
    chkb(low, 1'b0);
    $display("test reset done");
  endtask
  task t_dither;
    for (int c = 0; c < 8; c++) begin
      wr(8'h1F, 8'h09, 8'hF8 | c[7:0]);
      settle();
      chk8({4'h0, pix, lin, frm, rsv}, c == 0 ? 8'h08 : c == 1 ? 8'h04 :
        c == 2 ? 8'h02 : 8'h01);
    end
    rd(8'h1F, 8'h09, 8'h07);
    $display("test dither done");
  endtask
  task t_masks;
    mask_chk(8'h1B, 8'h0C, 8'h01);
    mask_chk(8'h1B, 8'h33, 8'h3F);
    mask_chk(8'h1B, 8'h34, 8'h3F);
    mask_chk(8'h1B, 8'h22, 8'h3F);
    mask_chk(8'h1B, 8'h23, 8'h3F);
    mask_chk(8'h1B, 8'h2D, 8'h1F);
    mask_chk(8'h1B, 8'h2E, 8'hF0);
    mask_chk(8'h1B, 8'h58, 8'h3F);
    mask_chk(8'h1B, 8'h5B, 8'h3F);
    mask_chk(8'h1B, 8'h5C, 8'hFF);
    mask_chk(8'h1B, 8'h5D, 8'hFF);
    mask_chk(8'h1D, 8'h2E, 8'h01);
    mask_chk(8'h1D, 8'h2F, 8'h77);
    mask_chk(8'h1D, 8'h31, 8'hF3);
    mask_chk(8'h1C, 8'h10, 8'hFF);
    mask_chk(8'h1C, 8'h11, 8'hFF);
    mask_chk(8'h1C, 8'h3E, 8'hFF);
    mask_chk(8'h1C, 8'h24, 8'h0F);
    mask_chk(8'h1C, 8'h6D, 8'hF0);
    mask_chk(8'h1C, 8'h80, 8'h80);
    mask_chk(8'h1C, 8'h8B, 8'h03);
    mask_chk(8'h1C, 8'h88, 8'h80);
    mask_chk(8'h1C, 8'h00, 8'h00);
    wr(8'h1B, 8'h2E, 8'hA0);
    rd(8'h1D, 8'h2E, 8'h01);
    rd(8'h1B, 8'h2E, 8'hA0);
    $display("test masks done");
  endtask
  task t_fields;
    chk8({2'h0, dtc}, 8'h3F);
    chk8({2'h0, ftc}, 8'h3F);
    chk8({tnr, hon, von, eon, aon, uauto, ton, 1'b0}, 8'hFE);
    chk8({1'b0, hlev, 2'h0, elev}, 8'h73);
    chk8({alev, blim}, 8'hFF);
    chk8(cgain, 8'hFF);
    chk8(sman | uman, 8'h00);
    chk8({shft, 2'h0, tamt}, 8'hF0);
    chk8({2'h0, tmin}, 8'h3F);
    chk8({2'h0, tmax}, 8'h3F);
    chk8({3'h0, tpk}, 8'h1F);
    chk8({clip, 3'h0, gen}, 8'hA1);
    chk8({dvol, 2'h0}, 8'hFC);
    chk8({2'h0, lpk}, 8'h3F);
    chk8(gh, 8'hFF);
    chk8(gl, 8'hFF);
    chk8(smin, 8'h80);
    chk8(smax, 8'h60);
    wr(8'h1C, 8'h12, 8'h40);
    wr(8'h1C, 8'h88, 8'h7F);
    wr(8'h1C, 8'h80, 8'h7F);
    wr(8'h1C, 8'h8B, 8'h01);
    wr(8'h1C, 8'h1C, 8'h70);
    wr(8'h1D, 8'h2F, 8'h10);
    settle();
    chk8(cgain, 8'h40);
    chk8(sman & uman, 8'hFF);
    chk8({shft, blim}, 8'h00);
    chk8({ton, uauto, hon, von, 2'h0, tamt}, 8'h12);
    chk8({5'h00, vlev}, 8'h01);
    chk8(smax, 8'h70);
    chkb(low, 1'b0);
    wr(8'h1C, 8'h1B, 8'h3F);
    settle();
    chkb(low, 1'b1);
    wr(8'h1C, 8'h1B, 8'h40);
    settle();
    chkb(low, 1'b0);
    chk8(smin, 8'h40);
    chkb(urun, 1'b1);
    wr(8'h1C, 8'h86, 8'h80);
    settle();
    chkb(urun, 1'b0);
    $display("test fields done");
  endtask
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 reset = 0;
    t_reset();
    t_dither();
    t_masks();
    t_fields();
    give_verdict();
  end
  initial begin
    #40000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
